// >>> verilog/scp_port.sv
`timescale 1ns/10ps
// Behaviour
// - Opcode byte, address byte, then data bytes
// - Write opcode stores bytes, address auto-increments
// - Read opcode shifts bytes out, address increments
// - 24-bit registers, high byte at lowest address
// - One write loads command and both data words
// - Extra data transactions continue the same external command (codes other than 0, 1, 2)
// - Read bytes follow opcode and address bytes
// - Ready output pulses low 1 us when done
// - Busy high from acceptance until processing ends
// - Busy poll read served at any time when boot input sampled low after reset
// - Busy is control mid byte bit zero
// - Command 1 writes selected filter register
// - Command 2 copies filter register into data one
// - Data changes falling edge, sampled rising edge
// - Select is active low for whole transaction
// - Commands accepted only when boot input sampled low after reset
module scp_port
	import scp_pkg::*;
#(
	parameter int PULSE_CYC = READY_PULSE_CYC
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic port_select_n,
	input wire logic port_serial_clock,
	input wire logic serial_data_in,
	input wire logic boot_source,
	output logic serial_data_out,
	output logic serial_data_oe,
	output logic ready_pulse_n,
	output logic cmd_busy_flag,
	output logic config_enabled,
	output logic filt_wr_en,
	output logic filt_rd_en,
	output logic [23:0] filt_addr,
	output logic [23:0] filt_wdata,
	input wire logic [23:0] filt_rdata,
	output logic ext_cmd_start,
	output logic ext_cmd_continue,
	output logic [23:0] ext_cmd_code,
	input wire logic ext_cmd_done
);
	initial
	begin
		if (PULSE_CYC < 2 || PULSE_CYC > 65535)
			$error("PULSE_CYC out of range");
	end

	// ==========================================================
	// Pin synchronisers
	logic sel_s1_reg, sel_s2_reg, sel_d_reg;
	logic sck_s1_reg, sck_s2_reg, sck_d_reg;
	logic din_s1_reg, din_s2_reg;
	logic boot_s1_reg, boot_s2_reg;

	always_ff @(posedge clk)
	begin
		sel_s1_reg <= port_select_n;
		sel_s2_reg <= sel_s1_reg;
		sck_s1_reg <= port_serial_clock;
		sck_s2_reg <= sck_s1_reg;
		din_s1_reg <= serial_data_in;
		din_s2_reg <= din_s1_reg;
		boot_s1_reg <= boot_source;
		boot_s2_reg <= boot_s1_reg;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sel_d_reg <= 1'b1;
			sck_d_reg <= 1'b0;
		end
		else
		begin
			sel_d_reg <= sel_s2_reg;
			sck_d_reg <= sck_s2_reg;
		end
	end

	// ==========================================================
	// Boot source capture
	logic [1:0] boot_wait_reg;
	logic config_enabled_reg;

	// Wait for the synchroniser to carry a post-reset level
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			boot_wait_reg <= 2'h0;
			config_enabled_reg <= 1'b0;
		end
		else if (boot_wait_reg != 2'(BOOT_SETTLE_CYC))
		begin
			boot_wait_reg <= boot_wait_reg + 2'h1;
			if (boot_wait_reg == 2'(BOOT_SETTLE_CYC - 1))
				config_enabled_reg <= ~boot_s2_reg;
		end
	end

	// ==========================================================
	// Frame decode
	logic sel_active, sck_rise, sck_fall, frame_end, byte_done;
	logic [7:0] rx_byte;
	logic [2:0] bit_cnt_reg;
	logic [7:0] rx_shift_reg, opcode_reg, addr_reg, tx_shift_reg;
	logic miso_oe_reg, launch_pend_reg, data_pend_reg;
	scp_phase_e phase_reg;

	assign sel_active = ~sel_s2_reg & config_enabled_reg;
	assign sck_rise = sck_s2_reg & ~sck_d_reg;
	assign sck_fall = ~sck_s2_reg & sck_d_reg;
	assign frame_end = sel_s2_reg & ~sel_d_reg;
	assign byte_done = sel_active & sck_rise & (bit_cnt_reg == 3'h7);
	assign rx_byte = {rx_shift_reg[6:0], din_s2_reg};

	logic [23:0] port_reg [NUM_REGS];
	logic busy_reg;
	logic [7:0] quot, rem;
	logic [1:0] lane_pos;
	logic in_map, wr_byte;

	assign quot = addr_reg / BYTES_PER_REG;
	assign rem = addr_reg % BYTES_PER_REG;
	assign lane_pos = 2'h2 - rem[1:0];
	assign in_map = addr_reg <= ADDR_LAST;
	assign wr_byte = byte_done & (phase_reg == PH_DATA) & (opcode_reg == OP_WRITE);

	function automatic logic [7:0] fetch_byte(input logic [7:0] a);
		logic [7:0] q;
		logic [7:0] r;
		logic [23:0] word;
		q = a / BYTES_PER_REG;
		r = a % BYTES_PER_REG;
		word = port_reg[q[1:0]];
		if (q[1:0] == 2'(IDX_CONTROL))
			word[BUSY_BIT] = busy_reg;
		if (a > ADDR_LAST)
			fetch_byte = 8'h00;
		else
			fetch_byte = word[(2 - r[1:0]) * 8 +: 8];
	endfunction

	always_ff @(posedge clk)
	begin
		if (reset || !sel_active)
		begin
			bit_cnt_reg <= 3'h0;
			phase_reg <= PH_OPCODE;
			rx_shift_reg <= 8'h00;
			tx_shift_reg <= 8'h00;
			miso_oe_reg <= 1'b0;
			if (reset)
			begin
				opcode_reg <= 8'h00;
				addr_reg <= 8'h00;
			end
		end
		else if (sck_rise)
		begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			rx_shift_reg <= rx_byte;
			if (bit_cnt_reg == 3'h7)
			begin
				case (phase_reg)
					PH_OPCODE:
					begin
						opcode_reg <= rx_byte;
						phase_reg <= PH_ADDRESS;
					end
					PH_ADDRESS:
					begin
						addr_reg <= rx_byte;
						phase_reg <= PH_DATA;
					end
					PH_DATA:
					begin
						if (opcode_reg == OP_WRITE)
							addr_reg <= addr_reg + 8'h01;
					end
					default:
						phase_reg <= PH_OPCODE;
				endcase
			end
		end
		else if (sck_fall && phase_reg == PH_DATA && opcode_reg == OP_READ)
		begin
			if (bit_cnt_reg == 3'h0)
			begin
				tx_shift_reg <= fetch_byte(addr_reg);
				miso_oe_reg <= ~fetch_byte(addr_reg) >> 7 != 8'h00;
				addr_reg <= addr_reg + 8'h01;
			end
			else
			begin
				tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
				miso_oe_reg <= ~tx_shift_reg[6];
			end
		end
	end

	// ==========================================================
	// Launch bookkeeping
	always_ff @(posedge clk)
	begin
		if (reset || frame_end)
		begin
			launch_pend_reg <= 1'b0;
			data_pend_reg <= 1'b0;
		end
		else if (wr_byte)
		begin
			if (addr_reg == ADDR_COMMAND_LOW)
				launch_pend_reg <= 1'b1;
			if (addr_reg >= ADDR_DATA_ONE && in_map)
				data_pend_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Command processor
	scp_proc_e state_reg;
	logic filt_wr_reg, filt_rd_reg, ext_start_reg, ext_cont_reg, multi_cmd;
	logic [23:0] filt_addr_reg, filt_wdata_reg, ext_code_reg;

	assign multi_cmd = port_reg[IDX_COMMAND] != CMD_NOP
		&& port_reg[IDX_COMMAND] != CMD_WRITE_FILT
		&& port_reg[IDX_COMMAND] != CMD_READ_FILT;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_reg <= ST_IDLE;
			busy_reg <= 1'b0;
			filt_wr_reg <= 1'b0;
			filt_rd_reg <= 1'b0;
			ext_start_reg <= 1'b0;
			ext_cont_reg <= 1'b0;
			filt_addr_reg <= 24'h000000;
			filt_wdata_reg <= 24'h000000;
			ext_code_reg <= 24'h000000;
		end
		else
		begin
			filt_wr_reg <= 1'b0;
			filt_rd_reg <= 1'b0;
			ext_start_reg <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (frame_end && launch_pend_reg)
					begin
						busy_reg <= 1'b1;
						ext_code_reg <= port_reg[IDX_COMMAND];
						filt_addr_reg <= port_reg[IDX_DATA_ONE];
						filt_wdata_reg <= port_reg[IDX_DATA_TWO];
						case (port_reg[IDX_COMMAND])
							CMD_NOP:
								state_reg <= ST_DONE;
							CMD_WRITE_FILT:
							begin
								filt_wr_reg <= 1'b1;
								state_reg <= ST_DONE;
							end
							CMD_READ_FILT:
							begin
								filt_rd_reg <= 1'b1;
								state_reg <= ST_READ_CAPTURE;
							end
							default:
							begin
								ext_start_reg <= 1'b1;
								ext_cont_reg <= 1'b0;
								state_reg <= ST_EXTERNAL;
							end
						endcase
					end
					else if (frame_end && data_pend_reg && multi_cmd)
					begin
						busy_reg <= 1'b1;
						ext_start_reg <= 1'b1;
						ext_cont_reg <= 1'b1;
						state_reg <= ST_EXTERNAL;
					end
				end
				ST_READ_CAPTURE:
					state_reg <= ST_DONE;
				ST_EXTERNAL:
				begin
					if (ext_cmd_done)
						state_reg <= ST_DONE;
				end
				ST_DONE:
				begin
					busy_reg <= 1'b0;
					state_reg <= ST_IDLE;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Port registers
	// Filter read result wins over a host write in the same cycle
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < NUM_REGS; i++)
				port_reg[i] <= PORT_REG_RESET;
		end
		else if (state_reg == ST_READ_CAPTURE)
			port_reg[IDX_DATA_ONE] <= filt_rdata;
		else if (wr_byte && in_map)
			port_reg[quot[1:0]][lane_pos * 8 +: 8] <= rx_byte;
	end

	// ==========================================================
	// Ready pulse
	logic [15:0] pulse_cnt_reg;
	logic ready_n_reg;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pulse_cnt_reg <= 16'h0000;
			ready_n_reg <= 1'b1;
		end
		else if (state_reg == ST_DONE)
		begin
			pulse_cnt_reg <= 16'(PULSE_CYC);
			ready_n_reg <= 1'b0;
		end
		else if (pulse_cnt_reg > 16'h0001)
			pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
		else
		begin
			pulse_cnt_reg <= 16'h0000;
			ready_n_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Outputs
	logic zero_reg;

	// Open-drain pin: only ever pulls low
	always_ff @(posedge clk)
	begin
		zero_reg <= 1'b0;
	end

	assign serial_data_out = zero_reg;
	assign serial_data_oe = miso_oe_reg;
	assign ready_pulse_n = ready_n_reg;
	assign cmd_busy_flag = busy_reg;
	assign config_enabled = config_enabled_reg;
	assign filt_wr_en = filt_wr_reg;
	assign filt_rd_en = filt_rd_reg;
	assign filt_addr = filt_addr_reg;
	assign filt_wdata = filt_wdata_reg;
	assign ext_cmd_start = ext_start_reg;
	assign ext_cmd_continue = ext_cont_reg;
	assign ext_cmd_code = ext_code_reg;
endmodule

// >>> verilog/scp_pkg.sv
package scp_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_FREQ_HZ = 40_000_000;
	localparam int READY_PULSE_NS = 1000;
	localparam int READY_PULSE_CYC = (READY_PULSE_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
	localparam int HOST_WAIT_US = 1000;
	localparam int BOOT_SETTLE_CYC = 3;
	// ==========================================================
	// Serial opcodes
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_READ = 8'h03;
	// ==========================================================
	// Port register byte addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_COMMAND = 8'h03;
	localparam logic [7:0] ADDR_COMMAND_LOW = 8'h05;
	localparam logic [7:0] ADDR_DATA_ONE = 8'h06;
	localparam logic [7:0] ADDR_DATA_TWO = 8'h09;
	localparam logic [7:0] ADDR_LAST = 8'h0B;
	localparam logic [7:0] BYTES_PER_REG = 8'h03;
	localparam int IDX_CONTROL = 0;
	localparam int IDX_COMMAND = 1;
	localparam int IDX_DATA_ONE = 2;
	localparam int IDX_DATA_TWO = 3;
	localparam int NUM_REGS = 4;
	// ==========================================================
	// Fields and reset values
	localparam int BUSY_BIT = 8;
	localparam logic [23:0] PORT_REG_RESET = 24'h000000;
	// ==========================================================
	// Command codes
	localparam logic [23:0] CMD_NOP = 24'h000000;
	localparam logic [23:0] CMD_WRITE_FILT = 24'h000001;
	localparam logic [23:0] CMD_READ_FILT = 24'h000002;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {PH_OPCODE, PH_ADDRESS, PH_DATA} scp_phase_e;
	typedef enum logic [2:0] {ST_IDLE, ST_READ_CAPTURE, ST_EXTERNAL, ST_DONE} scp_proc_e;
endpackage

// >>> verification/scp_props.sv
`timescale 1ns/10ps
// ==========================================================
// Checker on the port pins
module scp_props
	import scp_pkg::*;
#(
	parameter int PULSE_CYC = 4
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic port_select_n,
	input wire logic serial_data_oe,
	input wire logic ready_pulse_n,
	input wire logic cmd_busy_flag,
	input wire logic config_enabled,
	input wire logic filt_wr_en,
	input wire logic filt_rd_en,
	input wire logic ext_cmd_start,
	input wire logic ext_cmd_continue
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Width of each low pulse, read at its rising end
	logic [7:0] low_cnt_reg;
	always_ff @(posedge clk)
		if (reset || ready_pulse_n)
			low_cnt_reg <= 8'h00;
		else
			low_cnt_reg <= low_cnt_reg + 8'h01;
	a_wr_one_cycle: assert property (filt_wr_en |=> !filt_wr_en)
		else $error("write pulse too long");
	a_rd_one_cycle: assert property (filt_rd_en |=> !filt_rd_en)
		else $error("read pulse too long");
	a_busy_on_write: assert property (filt_wr_en |-> cmd_busy_flag)
		else $error("busy low at launch");
	a_ready_after_wr: assert property (filt_wr_en |-> ##2 !ready_pulse_n)
		else $error("no ready after write");
	a_ready_width: assert property ($rose(ready_pulse_n) |-> low_cnt_reg == PULSE_CYC)
		else $error("ready width wrong");
	a_idle_when_off: assert property (!config_enabled |-> !(filt_wr_en || filt_rd_en || ext_cmd_start))
		else $error("command while disabled");
	a_oe_released: assert property (port_select_n [*5] |-> !serial_data_oe)
		else $error("data driven while deselected");
	a_ready_not_busy: assert property (!ready_pulse_n |-> !cmd_busy_flag)
		else $error("busy during ready");
	c_write_cmd: cover property (filt_wr_en);
	c_read_cmd: cover property (filt_rd_en);
	c_continue: cover property (ext_cmd_start && ext_cmd_continue);
endmodule
bind scp_port scp_props #(.PULSE_CYC(PULSE_CYC)) scp_props_i (.clk, .reset, .port_select_n,
	.serial_data_oe, .ready_pulse_n, .cmd_busy_flag, .config_enabled, .filt_wr_en,
	.filt_rd_en, .ext_cmd_start, .ext_cmd_continue);

// >>> verification/scp_host.sv
`timescale 1ns/10ps
// ==========================================================
// Serial master, clock parked low between frames
module scp_host(
	output logic port_select_n,
	output logic port_serial_clock,
	output logic serial_data_in,
	input wire logic data_line
);
	initial
	begin
		port_select_n = 1'b1;
		port_serial_clock = 1'b0;
		serial_data_in = 1'b0;
	end
	// First n bytes of tx go out, left aligned
	task automatic frame(input int n, input logic [95:0] tx, output logic [95:0] rx);
		rx = 96'h0;
		port_select_n = 1'b0;
		for (int i = 0; i < n * 8; i++)
		begin
			serial_data_in = tx[95 - i];
			#100 port_serial_clock = 1'b1;
			rx[95 - i] = data_line;
			#100 port_serial_clock = 1'b0;
		end
		#100 serial_data_in = ~serial_data_in;
		port_select_n = 1'b1;
		// Select high for eight clocks, past the design's minimum gap
		#200;
	endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import scp_pkg::*;
	logic clk, reset, boot_source, ext_cmd_done;
	logic port_select_n, port_serial_clock, serial_data_in, serial_data_out, serial_data_oe;
	logic ready_pulse_n, cmd_busy_flag, config_enabled, filt_wr_en, filt_rd_en;
	logic ext_cmd_start, ext_cmd_continue;
	logic [23:0] filt_addr, filt_wdata, filt_rdata, ext_cmd_code, a, d;
	logic [47:0] wr_pair;
	logic [24:0] ext_seen;
	logic [95:0] rx;
	logic [31:0] seed;
	logic rdy_d;
	int mismatches = 0, samples_checked = 0, n_rdy = 0, n_ext = 0;
	// Pulled-up open-drain data line
	wire data_line = serial_data_oe ? 1'b0 : 1'b1;
	scp_port #(.PULSE_CYC(4)) scp_port_i (.clk(clk), .reset(reset),
		.port_select_n(port_select_n), .port_serial_clock(port_serial_clock),
		.serial_data_in(serial_data_in), .boot_source(boot_source),
		.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
		.ready_pulse_n(ready_pulse_n), .cmd_busy_flag(cmd_busy_flag),
		.config_enabled(config_enabled), .filt_wr_en(filt_wr_en), .filt_rd_en(filt_rd_en),
		.filt_addr(filt_addr), .filt_wdata(filt_wdata), .filt_rdata(filt_rdata),
		.ext_cmd_start(ext_cmd_start), .ext_cmd_continue(ext_cmd_continue),
		.ext_cmd_code(ext_cmd_code), .ext_cmd_done(ext_cmd_done));
	scp_host host_i (.port_select_n(port_select_n), .port_serial_clock(port_serial_clock),
		.serial_data_in(serial_data_in), .data_line(data_line));
	// ==========================================================
	// Monitors and helpers
	always @(posedge clk)
	begin
		if (filt_wr_en)
			wr_pair <= {filt_addr, filt_wdata};
		if (ext_cmd_start)
			ext_seen <= {ext_cmd_continue, ext_cmd_code};
		if (ext_cmd_start)
			n_ext <= n_ext + 1;
		rdy_d <= ready_pulse_n;
		if (rdy_d && !ready_pulse_n)
			n_rdy <= n_rdy + 1;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Stand-in filter register file: value follows the address
	function automatic logic [23:0] filt_model(input logic [23:0] x);
		return x ^ 24'h5A5A5A;
	endfunction
	assign filt_rdata = filt_model(filt_addr);
	task automatic check(input logic [24:0] seen, input logic [24:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic send(input int n, input logic [95:0] v);
		@(posedge clk) #1;
		host_i.frame(n, v, rx);
	endtask
	task automatic wait_on(input bit on_ext, input int target);
		for (int k = 0; k < 400 && (on_ext ? n_ext : n_rdy) != target; k++)
			@(posedge clk);
		check(25'(on_ext ? n_ext : n_rdy), 25'(target));
	endtask
	task automatic done_pulse;
		@(posedge clk) #1 ext_cmd_done = 1'b1;
		@(posedge clk) #1 ext_cmd_done = 1'b0;
	endtask
	task automatic do_reset(input logic boot);
		@(posedge clk) #1 boot_source = boot;
		reset = 1'b1;
		repeat (2) @(posedge clk);
		#1 reset = 1'b0;
		repeat (8) @(posedge clk);
		check(25'(config_enabled), 25'(!boot));
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========================================================
	// Clock, watchdog and sequence
	initial
	begin
		clk = 1'b0;
		forever
			#12.5 clk = ~clk;
	end
	initial
	begin
		#2_000_000;
		mismatches++;
		test_done();
	end
	initial
	begin
		reset = 1'b1;
		boot_source = 1'b0;
		ext_cmd_done = 1'b0;
		seed = 32'h9A1F;
		do_reset(1'b0);
		for (int r = 0; r < 3; r++)
		begin
			seed = lfsr(seed);
			a = (r == 0) ? 24'hFFFFFF : seed[23:0];
			seed = lfsr(seed);
			d = (r == 0) ? 24'h000000 : seed[23:0];
			send(11, {8'h02, 8'h03, 24'h000001, a, d, 8'h00});
			wait_on(1'b0, r + 1);
			check(25'(wr_pair[47:24]), 25'(a));
			check(25'(wr_pair[23:0]), 25'(d));
			check(25'(cmd_busy_flag), 25'h0);
			send(8, {8'h03, 8'h06, 80'h0});
			check(25'(rx[79:56]), 25'(a));
			check(25'(rx[55:32]), 25'(d));
		end
		send(5, {8'h02, 8'h03, 24'h000005, 56'h0});
		wait_on(1'b1, 1);
		check(25'(cmd_busy_flag), 25'h1);
		send(3, {8'h03, 8'h01, 80'h0});
		check(25'(rx[79:72]), 25'h01);
		check(ext_seen, {1'b0, 24'h000005});
		done_pulse();
		wait_on(1'b0, 4);
		send(3, {8'h03, 8'h01, 80'h0});
		check(25'(rx[79:72]), 25'h00);
		send(8, {8'h02, 8'h06, 48'h123456ABCDEF, 32'h0});
		wait_on(1'b1, 2);
		check(ext_seen, {1'b1, 24'h000005});
		done_pulse();
		wait_on(1'b0, 5);
		seed = lfsr(seed);
		send(8, {8'h02, 8'h03, 24'h000002, seed[23:0], 32'h0});
		wait_on(1'b0, 6);
		send(5, {8'h03, 8'h06, 80'h0});
		check(25'(rx[79:56]), 25'(filt_model(seed[23:0])));
		send(5, {8'h02, 8'h03, 24'h000000, 56'h0});
		wait_on(1'b0, 7);
		check(25'(cmd_busy_flag), 25'h0);
		check(25'(serial_data_out), 25'h0);
		do_reset(1'b1);
		send(11, {8'h02, 8'h03, 24'h000001, 56'h0, 8'h00});
		repeat (40) @(posedge clk);
		check(25'(n_rdy), 25'd7);
		test_done();
	end
endmodule
